// *** pkg/sslv_pkg.sv ***
`default_nettype none
package sslv_pkg;
    // mode select codes
    localparam logic [3:0] MODE_SLV7     = 4'h6;
    localparam logic [3:0] MODE_SLV10    = 4'h7;
    localparam logic [3:0] MODE_SLV7_SS  = 4'he;
    localparam logic [3:0] MODE_SLV10_SS = 4'hf;
    localparam logic [3:0] MODE_SS_ONLY  = 4'hb;
    // first byte prefix of a 10-bit address
    localparam logic [4:0] TEN_PREFIX    = 5'h1e;
    // scl rising edge counts within a byte
    localparam logic [3:0] BIT_NONE      = 4'h0;
    localparam logic [3:0] BIT_FIRST     = 4'h1;
    localparam logic [3:0] BIT_LAST     = 4'h8;
    localparam logic [3:0] BIT_ACK      = 4'h9;
    localparam logic [3:0] BIT_STEP     = 4'h1;
    // reset values, and the fixed low level driven on both pins
    localparam logic       LINE_IDLE     = 1'b1;
    localparam logic       OE_RELEASED   = 1'b1;
    localparam logic       PIN_LOW       = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_DATA = 3'h3,
        ST_TX   = 3'h2,
        ST_SKIP = 3'h6
    } sslv_state_t;

    typedef struct packed {
        logic        scl_m, scl_s, scl_p;
        logic        sda_m, sda_s, sda_p;
        logic        cap_m, cap_s;
        logic [1:0]  rise_d;
        sslv_state_t state;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic [7:0]  tx_sh;
        logic [7:0]  buf_q;
        logic [7:0]  own;
        logic        bf, ov, irq, ua, rw;
        logic        start_f, stop_f;
        logic        hit, acked, hold, sda_low;
        logic        ten_hi, ten_done, go_tx, ua_pend;
        logic        scl_oen, sda_oen, pin_lo;
    } sslv_core_t;

    typedef struct packed {
        logic sda_cap;
    } sslv_link_t;
endpackage
`default_nettype wire

// *** hw/sslv_i2c_slave.sv ***
`default_nettype none
module sslv_i2c_slave
    import sslv_pkg::*;
(
    input  wire logic       clk,             // system clock
    input  wire logic       resetn,          // synchronous reset
    input  wire logic       scl_clk,         // scl as link clock
    input  wire logic       scl_i,           // scl pin level
    input  wire logic       sda_i,           // sda pin level
    output logic            scl_o,           // scl drive level
    output logic            scl_oen,         // scl drive, low drives
    output logic            sda_o,           // sda drive level
    output logic            sda_oen,         // sda drive, low drives
    input  wire logic       scl_dir_in,      // pin_direction_register bit for scl
    input  wire logic       sda_dir_in,      // pin_direction_register bit for sda
    input  wire logic       module_enable,   // module_enable_bit
    input  wire logic [3:0] mode_select,     // mode_select_field
    input  wire logic       own_addr_wr,     // own_address_register write strobe
    input  wire logic [7:0] own_addr_wdata,  // own address write data
    input  wire logic       buf_rd,          // receive buffer read strobe
    input  wire logic       irq_clr,         // clears serial_port_irq_flag
    input  wire logic       ovf_clr,         // writes overflow flag to zero
    input  wire logic       tx_wr,           // transmit data write strobe
    input  wire logic [7:0] tx_wdata,        // transmit data
    input  wire logic       clock_release,   // releases held scl unless addr_update is set
    output logic [7:0]      own_addr,        // own_address_register
    output logic [7:0]      buf_data,        // receive_transmit_buffer
    output logic            buffer_full,     // buffer_full_flag
    output logic            receive_overflow,// receive_overflow_flag
    output logic            irq_flag,        // serial_port_irq_flag
    output logic            addr_update,     // address_update_flag
    output logic            rw_status,       // direction status
    output logic            start_seen,      // start condition seen last
    output logic            stop_seen        // stop condition seen last
);

    sslv_core_t r;
    sslv_core_t n;
    sslv_link_t lr;
    sslv_link_t ln;

    logic rise, fall, bit_ev, start_w, stop_w;
    logic is7, is10, ss_w, on_w, slave_on, pin_ok, drive_ok;
    logic ok_w, dec_w, fin_w, hit_w, m7, mhi, mlo, set_bf;

    // link side: sda sampled on each scl rising edge
    always_comb
    begin
        ln = lr;
        ln.sda_cap = sda_i;
    end

    always_ff @(posedge scl_clk)
        lr <= ln;

    always_comb
    begin
        n = r;
        n.scl_m = scl_i;
        n.scl_s = r.scl_m;
        n.scl_p = r.scl_s;
        n.sda_m = sda_i;
        n.sda_s = r.sda_m;
        n.sda_p = r.sda_s;
        n.cap_m = lr.sda_cap;
        n.cap_s = r.cap_m;
        rise = r.scl_s & ~r.scl_p;
        fall = ~r.scl_s & r.scl_p;
        // delay lets the captured bit settle through its synchroniser
        n.rise_d = {r.rise_d[0], rise};
        bit_ev = r.rise_d[1];
        start_w = r.scl_s & r.sda_p & ~r.sda_s;
        stop_w = r.scl_s & ~r.sda_p & r.sda_s;

        is7 = (mode_select == MODE_SLV7) | (mode_select == MODE_SLV7_SS);
        is10 = (mode_select == MODE_SLV10) | (mode_select == MODE_SLV10_SS);
        ss_w = (mode_select == MODE_SLV7_SS) | (mode_select == MODE_SLV10_SS) | (mode_select == MODE_SS_ONLY);
        on_w = module_enable & (is7 | is10 | ss_w);
        slave_on = on_w & (is7 | is10);
        pin_ok = scl_dir_in & sda_dir_in;
        drive_ok = on_w & pin_ok;

        ok_w = ~r.bf & ~r.ov;
        dec_w = 1'b0;
        fin_w = 1'b0;
        hit_w = 1'b0;
        set_bf = 1'b0;
        m7 = is7 & (r.sh[7:1] == r.own[7:1]);
        mhi = is10 & ~r.ten_hi & (r.sh[7:3] == TEN_PREFIX) & (r.sh[7:1] == r.own[7:1])
              & (~r.sh[0] | r.ten_done);
        mlo = is10 & r.ten_hi & (r.sh == r.own);

        // software side
        if (buf_rd)
            n.bf = 1'b0;
        if (irq_clr)
            n.irq = 1'b0;
        if (ovf_clr)
            n.ov = 1'b0;
        if (own_addr_wr)
        begin
            n.own = own_addr_wdata;
            if (~r.ten_done | (own_addr_wdata[7:3] == TEN_PREFIX))
            begin
                n.ua = 1'b0;
                n.hold = 1'b0;
            end
        end
        if (tx_wr)
        begin
            n.tx_sh = tx_wdata;
            if ((r.state == ST_TX) & (r.cnt == BIT_NONE))
                n.sda_low = ~tx_wdata[7];
        end
        if (clock_release & ~r.ua)
            n.hold = 1'b0;

        if (start_w)
        begin
            n.start_f = 1'b1;
            n.stop_f = 1'b0;
        end
        if (stop_w)
        begin
            n.stop_f = 1'b1;
            n.start_f = 1'b0;
        end
        if ((start_w | stop_w) & ss_w & on_w)
            n.irq = 1'b1;

        if (!slave_on)
        begin
            n.state = ST_IDLE;
            n.cnt = BIT_NONE;
            n.hold = 1'b0;
            n.sda_low = 1'b0;
            n.ua = 1'b0;
            n.ten_hi = 1'b0;
            n.ten_done = 1'b0;
        end
        else if (start_w)
        begin
            n.state = ST_ADDR;
            n.cnt = BIT_NONE;
            n.sda_low = 1'b0;
            n.hit = 1'b0;
            n.ten_hi = 1'b0;
        end
        else if (stop_w)
        begin
            n.state = ST_IDLE;
            n.sda_low = 1'b0;
            n.ten_hi = 1'b0;
            n.ten_done = 1'b0;
        end
        else
        begin
            unique case (r.state)
                ST_IDLE, ST_SKIP:
                    n.sda_low = 1'b0;
                ST_ADDR, ST_DATA:
                begin
                    if (bit_ev & (r.cnt != BIT_ACK))
                    begin
                        n.cnt = r.cnt + BIT_STEP;
                        if (r.cnt < BIT_LAST)
                        begin
                            n.sh = {r.sh[6:0], r.cap_s};
                        end
                    end
                    if (fall & (r.cnt == BIT_LAST))
                    begin
                        dec_w = 1'b1;
                        hit_w = (r.state == ST_DATA) | m7 | mhi | mlo;
                        n.go_tx = (r.state == ST_ADDR) & r.sh[0] & (m7 | mhi);
                        n.ua_pend = (mhi & ~r.sh[0]) | mlo;
                        if (hit_w)
                        begin
                            n.hit = 1'b1;
                            n.acked = ok_w;
                            n.sda_low = ok_w;
                        end
                        else
                            n.state = ST_SKIP;
                    end
                    if (fall & (r.cnt == BIT_ACK) & r.hit)
                    begin
                        fin_w = 1'b1;
                        n.sda_low = 1'b0;
                        n.cnt = BIT_NONE;
                        n.irq = 1'b1;
                        if (r.acked)
                        begin
                            n.buf_q = r.sh;
                            set_bf = 1'b1;
                        end
                        else if (r.bf & ~r.ov)
                        begin
                            n.ov = 1'b1;
                        end
                        if (r.state == ST_ADDR)
                        begin
                            if (!r.acked)
                                n.state = ST_SKIP;
                            else if (r.go_tx)
                            begin
                                n.rw = 1'b1;
                                n.hold = 1'b1;
                                n.state = ST_TX;
                            end
                            else
                            begin
                                n.rw = 1'b0;
                                if (r.ua_pend)
                                begin
                                    n.ua = 1'b1;
                                    n.hold = 1'b1;
                                end
                                n.ten_hi = r.ua_pend & ~r.ten_hi;
                                n.ten_done = r.ten_done | (r.ua_pend & r.ten_hi);
                                n.state = (r.ua_pend & ~r.ten_hi) ? ST_ADDR : ST_DATA;
                            end
                        end
                    end
                end
                ST_TX:
                begin
                    if (bit_ev & (r.cnt != BIT_ACK))
                    begin
                        n.cnt = r.cnt + BIT_STEP;
                        if ((r.cnt == BIT_LAST) & r.cap_s)
                        begin
                            n.state = ST_IDLE; // master did not acknowledge
                            n.rw = 1'b0;
                            n.cnt = BIT_NONE;
                        end
                    end
                    if (fall & (r.cnt >= BIT_FIRST) & (r.cnt < BIT_LAST))
                    begin
                        n.tx_sh = {r.tx_sh[6:0], 1'b0};
                        n.sda_low = ~r.tx_sh[6];
                    end
                    if (fall & (r.cnt == BIT_LAST))
                        n.sda_low = 1'b0;
                    if (fall & (r.cnt == BIT_ACK))
                    begin
                        n.cnt = BIT_NONE;
                        n.hold = 1'b1;
                        n.irq = 1'b1;
                    end
                end
                default:
                    n.state = ST_IDLE;
            endcase
        end

        if (set_bf)
            n.bf = 1'b1;
        if (!on_w)
        begin
            n.start_f = 1'b0;
            n.stop_f = 1'b0;
        end
        n.scl_oen = ~(drive_ok & n.hold);
        n.sda_oen = ~(drive_ok & n.sda_low);
        n.pin_lo = PIN_LOW;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            r <= '0;
            r.scl_m <= LINE_IDLE;
            r.scl_s <= LINE_IDLE;
            r.scl_p <= LINE_IDLE;
            r.sda_m <= LINE_IDLE;
            r.sda_s <= LINE_IDLE;
            r.sda_p <= LINE_IDLE;
            r.scl_oen <= OE_RELEASED;
            r.sda_oen <= OE_RELEASED;
        end
        else
        begin
            r <= n;
        end
    end

    assign scl_o = r.pin_lo;
    assign sda_o = r.pin_lo;
    assign scl_oen = r.scl_oen;
    assign sda_oen = r.sda_oen;
    assign own_addr = r.own;
    assign buf_data = r.buf_q;
    assign buffer_full = r.bf;
    assign receive_overflow = r.ov;
    assign irq_flag = r.irq;
    assign addr_update = r.ua;
    assign rw_status = r.rw;
    assign start_seen = r.start_f;
    assign stop_seen = r.stop_f;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_match;
        dec_w && hit_w && ok_w && drive_ok;
    endsequence
    sequence s_fin_nack;
        fin_w && !r.acked;
    endsequence

    property p_off_release;
        !module_enable |=> scl_oen && sda_oen;
    endproperty
    a_off_release: assert property (p_off_release) else $error("lines not released when disabled");

    property p_off_flags;
        !module_enable ##1 !module_enable |-> !start_seen && !stop_seen && r.state == ST_IDLE;
    endproperty
    a_off_flags: assert property (p_off_flags) else $error("state kept while disabled");

    property p_pin_dir;
        !(scl_dir_in && sda_dir_in) |=> scl_oen && sda_oen;
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("pin driven while not an input");

    property p_bf_clear;
        buf_rd && !set_bf |=> !buffer_full;
    endproperty
    a_bf_clear: assert property (p_bf_clear) else $error("buffer full not cleared by read");

    property p_ov_hold;
        receive_overflow && !ovf_clr |=> receive_overflow;
    endproperty
    a_ov_hold: assert property (p_ov_hold) else $error("overflow cleared without software");

    property p_irq_hold;
        irq_flag && !irq_clr |=> irq_flag;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq flag dropped by itself");

    property p_ov_set;
        s_fin_nack ##0 (r.bf && !r.ov) |=> receive_overflow && irq_flag;
    endproperty
    a_ov_set: assert property (p_ov_set) else $error("overflow not set");

    property p_no_load;
        s_fin_nack |=> $stable(buf_data) && irq_flag;
    endproperty
    a_no_load: assert property (p_no_load) else $error("buffer changed without ack");

    property p_load;
        fin_w && r.acked |=> buffer_full && irq_flag && buf_data == $past(r.sh);
    endproperty
    a_load: assert property (p_load) else $error("byte not loaded");

    property p_ack;
        s_match |=> !sda_oen;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not driven on match");

    property p_ua_hold;
        $rose(addr_update) && $past(drive_ok) |-> !scl_oen;
    endproperty
    a_ua_hold: assert property (p_ua_hold) else $error("scl not held with update flag");

    property p_start_irq;
        start_w && ss_w && module_enable |=> irq_flag && start_seen;
    endproperty
    a_start_irq: assert property (p_start_irq) else $error("start irq missing");

endmodule
`default_nettype wire

// *** dv/sslv_i2c_master.sv ***
`default_nettype none
module sslv_i2c_master (
    input  wire logic scl,     // scl wire level
    input  wire logic sda,     // sda wire level
    output logic      scl_drv, // low pulls scl down
    output logic      sda_drv  // low pulls sda down
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 203;
    // sda moves this long after scl falls, so the two never change together
    localparam int HOLD = 20;

    initial
    begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end

    // release scl, then wait out stretching by the slave, for at most 200 us
    task automatic scl_up();
        int n;
        scl_drv = 1'b1;
        n = 0;
        while (scl !== 1'b1 && n < 20000)
        begin
            #10;
            n++;
        end
        #HALF;
    endtask

    task automatic put_bit(input logic b, output logic r);
        #HOLD;
        sda_drv = b;
        #HALF;
        scl_up();
        r = sda;
        scl_drv = 1'b0;
    endtask

    // from idle and as a repeated start
    task automatic start();
        #HOLD;
        sda_drv = 1'b1;
        #HALF;
        scl_up();
        sda_drv = 1'b0;
        #HALF;
        scl_drv = 1'b0;
        #HALF;
    endtask

    task automatic stop();
        #HOLD;
        sda_drv = 1'b0;
        #HALF;
        scl_up();
        sda_drv = 1'b1;
        #HALF;
    endtask

    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            put_bit(tx[i], rx[i]);
        put_bit(ack_in, ack);
    endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`default_nettype none
module tb_top
    import sslv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, resetn, scl_dir, sda_dir, en, scl_drv, sda_drv;
    logic       scl_o, scl_oen, sda_o, sda_oen, bf, ov, irq, ua, rw, ss, ps;
    logic [3:0] mode;
    logic [5:0] stb;
    logic [7:0] wd, own, buf_data, rx;
    int         num_errors, total_checks;
    wire logic  scl;
    wire logic  sda;
    assign scl = scl_drv & (scl_oen | scl_o);
    assign sda = sda_drv & (sda_oen | sda_o);

    sslv_i2c_slave i_dut (.clk(clk), .resetn(resetn), .scl_clk(scl), .scl_i(scl), .sda_i(sda),
        .scl_o(scl_o), .scl_oen(scl_oen), .sda_o(sda_o), .sda_oen(sda_oen), .scl_dir_in(scl_dir),
        .sda_dir_in(sda_dir), .module_enable(en), .mode_select(mode), .own_addr_wr(stb[0]),
        .own_addr_wdata(wd), .buf_rd(stb[1]), .irq_clr(stb[2]), .ovf_clr(stb[3]), .tx_wr(stb[4]),
        .tx_wdata(wd), .clock_release(stb[5]), .own_addr(own), .buf_data(buf_data), .buffer_full(bf),
        .receive_overflow(ov), .irq_flag(irq), .addr_update(ua), .rw_status(rw), .start_seen(ss),
        .stop_seen(ps));
    sslv_i2c_master i_mst (.scl(scl), .sda(sda), .scl_drv(scl_drv), .sda_drv(sda_drv));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk4(input string n, input logic [3:0] e, input logic [3:0] g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // strobe 0 own address, 1 buffer read, 2 irq clear, 3 overflow clear, 4 tx write, 5 release
    task automatic pulse(input int k, input logic [7:0] d);
        @(negedge clk);
        stb[k] = 1'b1;
        wd = d;
        @(negedge clk);
        stb = 6'h00;
    endtask

    task automatic set_cfg(input logic e, input logic [3:0] m);
        @(negedge clk);
        en = e;
        mode = m;
    endtask

    task automatic clr();
        pulse(1, 8'h00);
        pulse(2, 8'h00);
    endtask

    task automatic byte_w(input logic [7:0] b, input logic exp_ack);
        logic a;
        i_mst.xfer(b, 1'b1, rx, a);
        chk1("ack", exp_ack, a);
        repeat (10) @(negedge clk);
    endtask

    task automatic byte_r(input logic [7:0] d);
        logic a;
        pulse(4, d);
        pulse(5, 8'h00);
        i_mst.xfer(8'hff, 1'b1, rx, a);
        chk8("tx_data", d, rx);
        i_mst.stop();
        clr();
    endtask

    task automatic t_write7();
        set_cfg(1'b1, MODE_SLV7);
        pulse(0, 8'ha0);
        i_mst.start();
        byte_w(8'ha0, 1'b0);
        chk8("buf", 8'ha0, buf_data);
        chk4("flags", 4'b1010, {bf, ov, irq, ua});
        chk1("rw", 1'b0, rw);
        pulse(2, 8'h00);
        byte_w(8'h3c, 1'b1);
        chk4("flags", 4'b1110, {bf, ov, irq, ua});
        chk8("buf", 8'ha0, buf_data);
        clr();
        byte_w(8'h11, 1'b1);
        chk4("flags", 4'b0110, {bf, ov, irq, ua});
        pulse(3, 8'h00);
        pulse(2, 8'h00);
        byte_w(8'h77, 1'b0);
        chk8("buf", 8'h77, buf_data);
        chk4("flags", 4'b1010, {bf, ov, irq, ua});
        i_mst.stop();
        clr();
    endtask

    task automatic t_miss();
        i_mst.start();
        byte_w(8'h00, 1'b1);
        i_mst.stop();
        i_mst.start();
        byte_w(8'h42, 1'b1);
        byte_w(8'h55, 1'b1);
        chk4("flags", 4'b0000, {bf, ov, irq, ua});
        i_mst.stop();
    endtask

    task automatic t_read();
        i_mst.start();
        byte_w(8'ha1, 1'b0);
        chk1("rw", 1'b1, rw);
        repeat (40) @(negedge clk);
        chk1("scl_held", 1'b0, scl_oen);
        byte_r(8'h5a);
    endtask

    task automatic t_ten();
        set_cfg(1'b1, MODE_SLV10);
        pulse(0, 8'hf2);
        i_mst.start();
        byte_w(8'hf2, 1'b0);
        chk4("flags", 4'b1011, {bf, ov, irq, ua});
        chk1("scl_held", 1'b0, scl_oen);
        pulse(0, 8'h34);
        chk1("ua", 1'b0, ua);
        chk8("own", 8'h34, own);
        chk1("scl_rel", 1'b1, scl_oen);
        clr();
        byte_w(8'h34, 1'b0);
        chk4("flags", 4'b1011, {bf, ov, irq, ua});
        pulse(0, 8'hf2);
        chk1("ua", 1'b0, ua);
        clr();
        byte_w(8'h99, 1'b0);
        chk8("buf", 8'h99, buf_data);
        clr();
        i_mst.start();
        byte_w(8'hf3, 1'b0);
        chk4("flags", 4'b1010, {bf, ov, irq, ua});
        byte_r(8'hc3);
    endtask

    task automatic t_modes();
        logic [3:0] m [5];
        logic       e [5];
        m = '{MODE_SLV7, MODE_SLV10, MODE_SLV7_SS, MODE_SLV10_SS, MODE_SS_ONLY};
        e = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
        for (int k = 0; k < 5; k++)
        begin
            set_cfg(1'b1, m[k]);
            pulse(2, 8'h00);
            i_mst.start();
            repeat (10) @(negedge clk);
            chk1("irq_start", e[k], irq);
            chk1("start_seen", 1'b1, ss);
            pulse(2, 8'h00);
            i_mst.stop();
            repeat (10) @(negedge clk);
            chk1("irq_stop", e[k], irq);
            chk1("stop_seen", 1'b1, ps);
        end
        pulse(0, 8'ha0);
        i_mst.start();
        byte_w(8'ha0, 1'b1);
        i_mst.stop();
        clr();
    endtask

    task automatic t_off();
        set_cfg(1'b1, MODE_SLV7);
        @(negedge clk);
        sda_dir = 1'b0;
        i_mst.start();
        byte_w(8'ha0, 1'b1);
        i_mst.stop();
        @(negedge clk);
        sda_dir = 1'b1;
        clr();
        set_cfg(1'b0, MODE_SLV7);
        i_mst.start();
        byte_w(8'ha0, 1'b1);
        i_mst.stop();
        set_cfg(1'b1, MODE_SLV7);
        i_mst.start();
        byte_w(8'ha1, 1'b0);
        set_cfg(1'b0, MODE_SLV7);
        repeat (10) @(negedge clk);
        chk4("oen", 4'b1101, {scl_oen, sda_oen, scl, sda});
        chk1("start_seen", 1'b0, ss);
        set_cfg(1'b1, MODE_SLV7);
        i_mst.stop();
        clr();
    endtask

    initial
    begin
        resetn = 1'b0;
        en = 1'b0;
        mode = MODE_SLV7;
        scl_dir = 1'b1;
        sda_dir = 1'b1;
        stb = 6'h00;
        wd = 8'h00;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (5) @(negedge clk);
        t_write7();
        t_miss();
        t_read();
        t_ten();
        t_modes();
        t_off();
        report_and_stop();
    end

    initial
    begin
        #800000;
        num_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
